// File: velocity_status_pkg.sv
// Contract
// - Speed-reached flag sets once speed exceeds arrival threshold, 10 to 2000 rpm.
// - Speed match compares the pre-ramp velocity command with measured speed.
// - Match flag valid while command minus speed magnitude lies inside window.
// - Match flag turns on only below window minus 10 rpm.
// - Match flag turns off only above window plus 10 rpm.
// - Zero-speed uses absolute speed feedback, both directions alike.
// - Torque mode switches to speed-limited control once limit is reached.
// - Speed limit not enforced while torque opposes actual rotation.
// - Speed above overspeed level raises overspeed error and stops motor.
// - Overspeed level zero means 1.2 times maximum motor speed.
package velocity_status_pkg;

    localparam int SPEED_W = 16;
    localparam int MAG_W = 19;
    localparam int PROD_W = 22;

    // Parameter indices
    localparam logic [15:0] IDX_ZERO = 16'h2434;
    localparam logic [15:0] IDX_MATCH = 16'h2435;
    localparam logic [15:0] IDX_ARRIVAL = 16'h2436;
    localparam logic [15:0] IDX_OVERSPEED = 16'h2513;
    localparam logic [15:0] IDX_STATUS = 16'h2400;

    // Reset values
    localparam logic [15:0] RST_ZERO = 16'h0032;
    localparam logic [15:0] RST_MATCH = 16'h0032;
    localparam logic [15:0] RST_ARRIVAL = 16'h03e8;
    localparam logic [15:0] RST_OVERSPEED = 16'h0000;

    // Legal ranges
    localparam logic [15:0] MIN_WINDOW = 16'h000a;
    localparam logic [15:0] MAX_WINDOW = 16'h07d0;
    localparam logic [15:0] MIN_ZERO = 16'h0000;
    localparam logic [15:0] MAX_OVERSPEED = 16'h2710;

    // Hysteresis and default overspeed ratio 6/5
    localparam logic [MAG_W-1:0] HYST_RPM = 19'h0000a;
    localparam logic [PROD_W-1:0] OVS_NUM = 22'h000006;
    localparam logic [PROD_W-1:0] OVS_DEN = 22'h000005;

    // Status word bit positions
    localparam int ST_BIT_REACHED = 0;
    localparam int ST_BIT_MATCH = 1;
    localparam int ST_BIT_ZERO = 2;
    localparam int ST_BIT_LIMIT = 3;
    localparam int ST_BIT_OVS = 4;

    typedef logic [MAG_W-1:0] mag_t;

    typedef enum logic [1:0] {
        ST_FREE = 2'h0,
        ST_LIMIT = 2'h1,
        ST_TRIP = 2'h3
    } drive_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] index;
        logic [15:0] wdata;
    } param_req_s;

    typedef struct packed {
        logic signed [SPEED_W-1:0] speed_fb;
        logic signed [SPEED_W-1:0] velocity_cmd;
        logic signed [SPEED_W-1:0] torque_cmd;
    } motion_s;

endpackage : velocity_status_pkg

// File: velocity_status_monitor.sv
`timescale 1ns/10ps
module velocity_status_monitor
    import velocity_status_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire motion_s motion,
    input wire logic torque_mode,
    input wire logic [15:0] velocity_limit,
    input wire logic [15:0] max_motor_speed,
    input wire logic error_clear,
    input wire param_req_s param_req,
    output logic [15:0] param_rdata,
    output logic param_ack,
    output logic param_err,
    output logic speed_reached_flag,
    output logic speed_match_flag,
    output logic zero_speed_flag,
    output logic speed_limit_active,
    output logic overspeed_error,
    output logic signed [SPEED_W-1:0] torque_cmd_out
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic mag_t mag17(input logic signed [16:0] v);
        logic signed [MAG_W-1:0] w;
        w = {{2{v[16]}}, v};
        mag17 = w[MAG_W-1] ? mag_t'(-w) : mag_t'(w);
    endfunction : mag17

    function automatic logic [15:0] clamp16(input logic [15:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp16

    function automatic mag_t ext(input logic [15:0] v);
        ext = {3'h0, v};
    endfunction : ext

    ////////////////////////////////////////////////////////////////////////
    // Parameter registers

    logic [15:0] zero_speed_threshold;
    logic [15:0] speed_match_window;
    logic [15:0] arrival_speed_threshold;
    logic [15:0] overspeed_level;
    logic [15:0] status_word;
    logic index_hit;

    always_comb begin
        index_hit = (param_req.index == IDX_ZERO) ||
                    (param_req.index == IDX_MATCH) ||
                    (param_req.index == IDX_ARRIVAL) ||
                    (param_req.index == IDX_OVERSPEED) ||
                    (param_req.index == IDX_STATUS);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            zero_speed_threshold <= RST_ZERO;
            speed_match_window <= RST_MATCH;
            arrival_speed_threshold <= RST_ARRIVAL;
            overspeed_level <= RST_OVERSPEED;
        end else if (clk_en && param_req.wr) begin
            if (param_req.index == IDX_ZERO) begin
                zero_speed_threshold <= param_req.wdata;
            end else if (param_req.index == IDX_MATCH) begin
                speed_match_window <= clamp16(param_req.wdata, MIN_WINDOW,
                                              MAX_WINDOW);
            end else if (param_req.index == IDX_ARRIVAL) begin
                arrival_speed_threshold <= clamp16(param_req.wdata,
                                                   MIN_WINDOW,
                                                   MAX_WINDOW);
            end else if (param_req.index == IDX_OVERSPEED) begin
                overspeed_level <= clamp16(param_req.wdata, MIN_ZERO,
                                           MAX_OVERSPEED);
            end
        end
    end

    always_comb begin
        status_word = '0;
        status_word[ST_BIT_REACHED] = speed_reached_flag;
        status_word[ST_BIT_MATCH] = speed_match_flag;
        status_word[ST_BIT_ZERO] = zero_speed_flag;
        status_word[ST_BIT_LIMIT] = speed_limit_active;
        status_word[ST_BIT_OVS] = overspeed_error;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            param_rdata <= '0;
            param_ack <= 1'b0;
            param_err <= 1'b0;
        end else if (clk_en) begin
            param_ack <= param_req.wr || param_req.rd;
            param_err <= (param_req.wr || param_req.rd) && !index_hit;
            if (!param_req.rd) begin
                param_rdata <= '0;
            end else if (param_req.index == IDX_ZERO) begin
                param_rdata <= zero_speed_threshold;
            end else if (param_req.index == IDX_MATCH) begin
                param_rdata <= speed_match_window;
            end else if (param_req.index == IDX_ARRIVAL) begin
                param_rdata <= arrival_speed_threshold;
            end else if (param_req.index == IDX_OVERSPEED) begin
                param_rdata <= overspeed_level;
            end else if (param_req.index == IDX_STATUS) begin
                param_rdata <= status_word;
            end else begin
                param_rdata <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Speed comparisons

    mag_t spd_mag;
    mag_t diff_mag;
    mag_t ovs_thr;
    logic [PROD_W-1:0] max_x6;
    logic opposing;
    logic at_limit;
    logic ovs_hit;

    always_comb begin
        spd_mag = mag17({motion.speed_fb[SPEED_W-1], motion.speed_fb});
        diff_mag = mag17({motion.velocity_cmd[SPEED_W-1],
                          motion.velocity_cmd} -
                         {motion.speed_fb[SPEED_W-1], motion.speed_fb});
        max_x6 = {6'h00, max_motor_speed} * OVS_NUM;
        if (overspeed_level == '0) begin
            ovs_thr = MAG_W'(max_x6 / OVS_DEN);
        end else begin
            ovs_thr = ext(overspeed_level);
        end
        ovs_hit = spd_mag > ovs_thr;
        at_limit = spd_mag >= ext(velocity_limit);
        opposing = (motion.torque_cmd != '0) && (motion.speed_fb != '0) &&
                   (motion.torque_cmd[SPEED_W-1] !=
                    motion.speed_fb[SPEED_W-1]);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            speed_reached_flag <= 1'b0;
        end else if (clk_en) begin
            if (spd_mag > ext(arrival_speed_threshold)) begin
                speed_reached_flag <= 1'b1;
            end else if (spd_mag + HYST_RPM <
                         ext(arrival_speed_threshold)) begin
                speed_reached_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            speed_match_flag <= 1'b0;
        end else if (clk_en) begin
            if (diff_mag + HYST_RPM < ext(speed_match_window)) begin
                speed_match_flag <= 1'b1;
            end else if (diff_mag > ext(speed_match_window) + HYST_RPM) begin
                speed_match_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            zero_speed_flag <= 1'b0;
        end else if (clk_en) begin
            if (spd_mag + HYST_RPM < ext(zero_speed_threshold)) begin
                zero_speed_flag <= 1'b1;
            end else if (spd_mag > ext(zero_speed_threshold) + HYST_RPM) begin
                zero_speed_flag <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Torque-mode limit and overspeed trip

    drive_state_e state;
    drive_state_e next_state;

    always_comb begin
        next_state = state;
        case (state)
            ST_FREE: begin
                if (ovs_hit) begin
                    next_state = ST_TRIP;
                end else if (torque_mode && at_limit && !opposing) begin
                    next_state = ST_LIMIT;
                end
            end
            ST_LIMIT: begin
                if (ovs_hit) begin
                    next_state = ST_TRIP;
                end else if (!torque_mode || !at_limit || opposing) begin
                    next_state = ST_FREE;
                end
            end
            ST_TRIP: begin
                if (error_clear && !ovs_hit) begin
                    next_state = ST_FREE;
                end
            end
            default: begin
                next_state = ST_TRIP;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= ST_FREE;
            speed_limit_active <= 1'b0;
            overspeed_error <= 1'b0;
            torque_cmd_out <= '0;
        end else if (clk_en) begin
            state <= next_state;
            speed_limit_active <= next_state == ST_LIMIT;
            overspeed_error <= next_state == ST_TRIP;
            if (next_state == ST_FREE) begin
                torque_cmd_out <= motion.torque_cmd;
            end else begin
                torque_cmd_out <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    logic [PROD_W-1:0] spd_x5;
    assign spd_x5 = {3'h0, spd_mag} * OVS_DEN;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    property p_reached_on;
        clk_en && spd_mag > ext(arrival_speed_threshold) |=>
            speed_reached_flag;
    endproperty
    a_reached_on: assert property (p_reached_on)
        else $error("speed reached flag missing");

    property p_reached_hold;
        clk_en && speed_reached_flag &&
        spd_mag + HYST_RPM >= ext(arrival_speed_threshold) |=>
            speed_reached_flag;
    endproperty
    a_reached_hold: assert property (p_reached_hold)
        else $error("speed reached flag dropped inside band");

    property p_match_equal;
        clk_en && motion.velocity_cmd == motion.speed_fb &&
        ext(speed_match_window) > HYST_RPM |=> speed_match_flag;
    endproperty
    a_match_equal: assert property (p_match_equal)
        else $error("equal command and speed not matched");

    property p_match_on;
        clk_en && !speed_match_flag &&
        diff_mag + HYST_RPM >= ext(speed_match_window) |=> !speed_match_flag;
    endproperty
    a_match_on: assert property (p_match_on)
        else $error("match flag rose outside inner band");

    property p_match_off;
        clk_en && diff_mag > ext(speed_match_window) + HYST_RPM |=>
            !speed_match_flag;
    endproperty
    a_match_off: assert property (p_match_off)
        else $error("match flag stayed on outside outer band");

    property p_match_keep;
        clk_en && speed_match_flag &&
        diff_mag <= ext(speed_match_window) + HYST_RPM |=> speed_match_flag;
    endproperty
    a_match_keep: assert property (p_match_keep)
        else $error("match flag dropped inside window");

    property p_zero;
        clk_en && spd_mag + HYST_RPM < ext(zero_speed_threshold) |=>
            zero_speed_flag;
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero speed flag missing");

    property p_zero_dir;
        clk_en && $past(clk_en) && $stable(spd_mag) &&
        $changed(motion.speed_fb) |=>
            $stable(zero_speed_flag);
    endproperty
    a_zero_dir: assert property (p_zero_dir)
        else $error("zero speed depends on direction");

    property p_limit;
        clk_en && state == ST_FREE && torque_mode && at_limit &&
        !opposing && !ovs_hit |=> speed_limit_active;
    endproperty
    a_limit: assert property (p_limit)
        else $error("speed limit not engaged");

    property p_opposing;
        clk_en && opposing |=> !speed_limit_active;
    endproperty
    a_opposing: assert property (p_opposing)
        else $error("limit enforced against opposing torque");

    property p_trip;
        clk_en && ovs_hit |=> overspeed_error && torque_cmd_out == '0 ##1
            (overspeed_error || $past(clk_en && error_clear));
    endproperty
    a_trip: assert property (p_trip)
        else $error("overspeed did not stop motor");

    property p_default_level;
        clk_en && overspeed_level == '0 && spd_x5 > max_x6 |=>
            overspeed_error;
    endproperty
    a_default_level: assert property (p_default_level)
        else $error("default overspeed level not applied");

    c_reached: cover property (clk_en && $rose(speed_reached_flag));
    c_match: cover property ($rose(speed_match_flag) ##[1:50]
                             $fell(speed_match_flag));
    c_limit: cover property ($rose(speed_limit_active));
    c_trip: cover property ($rose(overspeed_error) ##[1:50]
                            $fell(overspeed_error));

endmodule : velocity_status_monitor

// File: motion_source.sv
`timescale 1ns/10ps
module motion_source
    import velocity_status_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic signed [SPEED_W-1:0] target,
    input wire logic signed [SPEED_W:0] step,
    input wire logic signed [SPEED_W-1:0] cmd,
    input wire logic signed [SPEED_W-1:0] trq,
    output motion_s motion
);
    logic signed [SPEED_W:0] diff;

    ////////////////////////////////////////////////////////////////////////
    // Motor speed slews toward target, at most step rpm per cycle
    always_comb begin
        diff = {target[SPEED_W-1], target};
        diff = diff - {motion.speed_fb[SPEED_W-1], motion.speed_fb};
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            motion <= '0;
        end else begin
            if (diff > step) begin
                motion.speed_fb <= motion.speed_fb + step[SPEED_W-1:0];
            end else if (diff < -step) begin
                motion.speed_fb <= motion.speed_fb - step[SPEED_W-1:0];
            end else begin
                motion.speed_fb <= target;
            end
            // Command is the unramped value
            motion.velocity_cmd <= cmd;
            motion.torque_cmd <= trq;
        end
    end
endmodule : motion_source

// File: tb.sv
`timescale 1ns/10ps
`define CHK(a, b) \
    begin \
        checks_done++; \
        if ((a) !== (b)) begin \
            num_errors++; \
            $display("unexpected at %0t: %h not %h", $time, a, b); \
        end \
    end
module tb
    import velocity_status_pkg::*;
;
    int num_errors = 0;
    int checks_done = 0;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    logic torque_mode = 1'b0;
    logic error_clear = 1'b0;
    logic [15:0] velocity_limit = 16'h0320;
    logic [15:0] max_motor_speed = 16'h0bb8;
    param_req_s preq = '0;
    logic signed [SPEED_W-1:0] target = '0;
    logic signed [SPEED_W-1:0] cmd = '0;
    logic signed [SPEED_W-1:0] trq = '0;
    logic signed [SPEED_W:0] step = 17'sh0ffff;
    motion_s motion;
    logic [15:0] param_rdata;
    logic param_ack, param_err, speed_reached_flag, speed_match_flag;
    logic zero_speed_flag, speed_limit_active, overspeed_error;
    logic signed [SPEED_W-1:0] torque_cmd_out;

    always #5 ref_clk = ~ref_clk;

    motion_source motion_source_i (.ref_clk(ref_clk), .srst(srst),
        .target(target), .step(step), .cmd(cmd), .trq(trq),
        .motion(motion));

    velocity_status_monitor velocity_status_monitor_i (.ref_clk(ref_clk),
        .srst(srst), .clk_en(clk_en), .motion(motion),
        .torque_mode(torque_mode), .velocity_limit(velocity_limit),
        .max_motor_speed(max_motor_speed), .error_clear(error_clear),
        .param_req(preq), .param_rdata(param_rdata), .param_ack(param_ack),
        .param_err(param_err), .speed_reached_flag(speed_reached_flag),
        .speed_match_flag(speed_match_flag),
        .zero_speed_flag(zero_speed_flag),
        .speed_limit_active(speed_limit_active),
        .overspeed_error(overspeed_error), .torque_cmd_out(torque_cmd_out));

    ////////////////////////////////////////////////////////////////////////
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    task access(input logic w, input logic [15:0] idx, input logic [15:0] d,
                input logic [15:0] exp, input logic e);
        @(posedge ref_clk) #1;
        preq = '{wr: w, rd: !w, index: idx, wdata: d};
        @(posedge ref_clk) #1;
        preq = '0;
        `CHK(param_ack, 1'b1)
        `CHK(param_err, e)
        if (!w) `CHK(param_rdata, exp)
    endtask : access

    // Sets speed target and commands, waits until flags follow
    task go(input int fb, input int c, input int t);
        int n;
        @(posedge ref_clk) #1;
        target = fb[15:0];
        cmd = c[15:0];
        trq = t[15:0];
        n = 0;
        while (motion.speed_fb !== target && n < 3000) begin
            @(posedge ref_clk) #1;
            n++;
        end
        if (n >= 3000) begin
            num_errors++;
            conclude();
        end
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : go

    task pulse_clear;
        @(posedge ref_clk) #1;
        error_clear = 1'b1;
        @(posedge ref_clk) #1;
        error_clear = 1'b0;
        @(posedge ref_clk) #1;
    endtask : pulse_clear

    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        access(1'b0, IDX_STATUS, 16'h0, 16'h0006, 1'b0);
        access(1'b0, IDX_ZERO, 16'h0, RST_ZERO, 1'b0);
        access(1'b0, IDX_MATCH, 16'h0, RST_MATCH, 1'b0);
        access(1'b0, IDX_ARRIVAL, 16'h0, RST_ARRIVAL, 1'b0);
        access(1'b0, IDX_OVERSPEED, 16'h0, RST_OVERSPEED, 1'b0);
        access(1'b0, 16'h1234, 16'h0, 16'h0000, 1'b1);
        access(1'b1, 16'h1234, 16'h0055, 16'h0, 1'b1);
        access(1'b1, IDX_STATUS, 16'hffff, 16'h0, 1'b0);
        $display("end t_reset");
    endtask : t_reset

    task t_saturate;
        access(1'b1, IDX_MATCH, 16'h0005, 16'h0, 1'b0);
        access(1'b0, IDX_MATCH, 16'h0, MIN_WINDOW, 1'b0);
        access(1'b1, IDX_ARRIVAL, 16'h0bb8, 16'h0, 1'b0);
        access(1'b0, IDX_ARRIVAL, 16'h0, MAX_WINDOW, 1'b0);
        access(1'b1, IDX_OVERSPEED, 16'h4e20, 16'h0, 1'b0);
        access(1'b0, IDX_OVERSPEED, 16'h0, MAX_OVERSPEED, 1'b0);
        access(1'b1, IDX_MATCH, 16'h0032, 16'h0, 1'b0);
        access(1'b1, IDX_ARRIVAL, 16'h03e8, 16'h0, 1'b0);
        access(1'b1, IDX_OVERSPEED, 16'h0000, 16'h0, 1'b0);
        $display("end t_saturate");
    endtask : t_saturate

    task t_reached;
        step = 17'sd4;
        go(1001, 0, 0);
        `CHK(speed_reached_flag, 1'b1)
        step = 17'sh0ffff;
        go(995, 0, 0);
        `CHK(speed_reached_flag, 1'b1)
        go(989, 0, 0);
        `CHK(speed_reached_flag, 1'b0)
        go(1000, 0, 0);
        `CHK(speed_reached_flag, 1'b0)
        $display("end t_reached");
    endtask : t_reached

    task t_match;
        go(500, 500, 0);
        `CHK(speed_match_flag, 1'b1)
        go(445, 500, 0);
        `CHK(speed_match_flag, 1'b1)
        go(439, 500, 0);
        `CHK(speed_match_flag, 1'b0)
        go(460, 500, 0);
        `CHK(speed_match_flag, 1'b0)
        go(461, 500, 0);
        `CHK(speed_match_flag, 1'b1)
        go(-500, -440, 0);
        `CHK(speed_match_flag, 1'b1)
        go(-500, -439, 0);
        `CHK(speed_match_flag, 1'b0)
        $display("end t_match");
    endtask : t_match

    task t_zero;
        go(-61, 0, 0);
        `CHK(zero_speed_flag, 1'b0)
        go(-40, 0, 0);
        `CHK(zero_speed_flag, 1'b0)
        go(-39, 0, 0);
        `CHK(zero_speed_flag, 1'b1)
        go(-60, 0, 0);
        `CHK(zero_speed_flag, 1'b1)
        go(61, 0, 0);
        `CHK(zero_speed_flag, 1'b0)
        $display("end t_zero");
    endtask : t_zero

    task t_limit;
        torque_mode = 1'b1;
        go(799, 0, 100);
        `CHK(speed_limit_active, 1'b0)
        `CHK(torque_cmd_out, 16'h0064)
        go(800, 0, 100);
        `CHK(speed_limit_active, 1'b1)
        `CHK(torque_cmd_out, 16'h0000)
        go(800, 0, -100);
        `CHK(speed_limit_active, 1'b0)
        `CHK(torque_cmd_out, 16'hff9c)
        go(-800, 0, -100);
        `CHK(speed_limit_active, 1'b1)
        torque_mode = 1'b0;
        $display("end t_limit");
    endtask : t_limit

    task t_overspeed;
        go(3600, 0, 100);
        `CHK(overspeed_error, 1'b0)
        `CHK(speed_limit_active, 1'b0)
        go(3601, 0, 100);
        `CHK(overspeed_error, 1'b1)
        `CHK(torque_cmd_out, 16'h0000)
        go(3000, 0, 100);
        `CHK(overspeed_error, 1'b1)
        pulse_clear();
        `CHK(overspeed_error, 1'b0)
        `CHK(torque_cmd_out, 16'h0064)
        access(1'b1, IDX_OVERSPEED, 16'h07d0, 16'h0, 1'b0);
        go(2001, 0, 100);
        `CHK(overspeed_error, 1'b1)
        pulse_clear();
        `CHK(overspeed_error, 1'b1)
        go(1500, 0, 100);
        pulse_clear();
        `CHK(overspeed_error, 1'b0)
        $display("end t_overspeed");
    endtask : t_overspeed

    // Flags freeze while the clock enable is low
    task t_freeze;
        clk_en = 1'b0;
        go(0, 0, 0);
        `CHK(speed_reached_flag, 1'b1)
        `CHK(zero_speed_flag, 1'b0)
        `CHK(speed_match_flag, 1'b0)
        clk_en = 1'b1;
        go(0, 0, 0);
        `CHK(speed_reached_flag, 1'b0)
        `CHK(zero_speed_flag, 1'b1)
        `CHK(speed_match_flag, 1'b1)
        $display("end t_freeze");
    endtask : t_freeze

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        t_reset();
        t_saturate();
        t_reached();
        t_match();
        t_zero();
        t_limit();
        t_overspeed();
        t_freeze();
        conclude();
    end
endmodule : tb
